// file: hdl/iprc_top.sv
// Behaviour
// - Field code 111 gives the source level 7, the highest.
// - Code 001 gives level 1, the lowest enabled, and codes between map straight to 2..6.
// - Code 000 disables the source so it never requests service.
// - Unimplemented bits read zero and ignore writes.
// - Every implemented field resets to 100, level 4.
// - Register six holds timer four 14-12, compare four 10-8, compare three 6-4, dma two 2-0.
// - Register seven holds uart b transmit 14-12, receive 10-8, ext irq two 6-4, timer five 2-0.
// - Register eight holds can event 14-12, can receive 10-8, spi b event 6-4, spi b error 2-0.
// - Register nine holds only dma three in 2-0; bits 15-3 read zero.
// - Bits 15, 11, 7 and 3 of full registers are unused spacers.
`timescale 1ns/1ps
`default_nettype none
module iprc_top
    import iprc_pkg::*;
(
    input  wire logic                              i_core_clk,
    input  wire logic                              i_rst,
    input  wire logic [IPRC_ADDR_W-1:0]            i_address,
    input  wire logic                              i_read,
    input  wire logic                              i_write,
    input  wire logic [IPRC_DATA_W-1:0]            i_writedata,
    input  wire logic [3:0]                        i_byteenable,
    output logic      [IPRC_DATA_W-1:0]            o_readdata,
    output logic                                   o_waitrequest,
    output logic                                   o_readdatavalid,
    input  wire logic [IPRC_NUM_SRC-1:0]           i_src_req,
    output logic      [IPRC_NUM_SRC*IPRC_PRIO_W-1:0] o_src_prio,
    output logic                                   o_irq_valid,
    output logic      [3:0]                        o_irq_src,
    output logic      [IPRC_PRIO_W-1:0]            o_irq_level
);

    logic [IPRC_REG_W-1:0] reg_six;
    logic [IPRC_REG_W-1:0] reg_seven;
    logic [IPRC_REG_W-1:0] reg_eight;
    logic [IPRC_REG_W-1:0] reg_nine;
    logic [IPRC_NUM_REG-1:0] sel;
    logic                  ack;
    logic [IPRC_REG_W-1:0] rd_mux;
    iprc_winner_s          winner;

    // One wait cycle per access: the slave accepts on its second cycle
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (i_read || i_write) && !ack;
        end
    end

    assign o_waitrequest = (i_read || i_write) && !ack;

    always_comb begin
        sel = '0;
        case (i_address)
            IPRC_OFF_SIX:   sel[0] = 1'b1;
            IPRC_OFF_SEVEN: sel[1] = 1'b1;
            IPRC_OFF_EIGHT: sel[2] = 1'b1;
            IPRC_OFF_NINE:  sel[3] = 1'b1;
            default:        sel = '0;
        endcase
    end

    iprc_field_reg #(.MASK(IPRC_MASK_FULL), .RESET_VAL(IPRC_RST_FULL)) u_six (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_wr       (i_write && ack && sel[0]),
        .i_be       (i_byteenable[1:0]),
        .i_wdata    (i_writedata[IPRC_REG_W-1:0]),
        .o_value    (reg_six)
    );

    iprc_field_reg #(.MASK(IPRC_MASK_FULL), .RESET_VAL(IPRC_RST_FULL)) u_seven (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_wr       (i_write && ack && sel[1]),
        .i_be       (i_byteenable[1:0]),
        .i_wdata    (i_writedata[IPRC_REG_W-1:0]),
        .o_value    (reg_seven)
    );

    iprc_field_reg #(.MASK(IPRC_MASK_FULL), .RESET_VAL(IPRC_RST_FULL)) u_eight (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_wr       (i_write && ack && sel[2]),
        .i_be       (i_byteenable[1:0]),
        .i_wdata    (i_writedata[IPRC_REG_W-1:0]),
        .o_value    (reg_eight)
    );

    iprc_field_reg #(.MASK(IPRC_MASK_NINE), .RESET_VAL(IPRC_RST_NINE)) u_nine (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_wr       (i_write && ack && sel[3]),
        .i_be       (i_byteenable[1:0]),
        .i_wdata    (i_writedata[IPRC_REG_W-1:0]),
        .o_value    (reg_nine)
    );

    always_comb begin
        case (sel)
            4'h1:    rd_mux = reg_six;
            4'h2:    rd_mux = reg_seven;
            4'h4:    rd_mux = reg_eight;
            4'h8:    rd_mux = reg_nine;
            default: rd_mux = '0;
        endcase
    end

    // Read data registered at the edge ending the wait cycle; unmapped reads return zero
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_readdata <= '0;
        end else if (i_read && !ack) begin
            o_readdata <= {{(IPRC_DATA_W-IPRC_REG_W){1'b0}}, rd_mux};
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_readdatavalid <= 1'b0;
        end else begin
            o_readdatavalid <= i_read && !ack;
        end
    end

    // Field placement into the per-source priority vector
    always_comb begin
        o_src_prio = '0;
        o_src_prio[IPRC_SRC_TMR4*IPRC_PRIO_W +: IPRC_PRIO_W]   =
            reg_six[IPRC_FLD_HI +: IPRC_PRIO_W];
        o_src_prio[IPRC_SRC_OC4*IPRC_PRIO_W +: IPRC_PRIO_W]    =
            reg_six[IPRC_FLD_MH +: IPRC_PRIO_W];
        o_src_prio[IPRC_SRC_OC3*IPRC_PRIO_W +: IPRC_PRIO_W]    =
            reg_six[IPRC_FLD_ML +: IPRC_PRIO_W];
        o_src_prio[IPRC_SRC_DMA2*IPRC_PRIO_W +: IPRC_PRIO_W]   =
            reg_six[IPRC_FLD_LO +: IPRC_PRIO_W];
        o_src_prio[IPRC_SRC_UTX*IPRC_PRIO_W +: IPRC_PRIO_W]    =
            reg_seven[IPRC_FLD_HI +: IPRC_PRIO_W];
        o_src_prio[IPRC_SRC_URX*IPRC_PRIO_W +: IPRC_PRIO_W]    =
            reg_seven[IPRC_FLD_MH +: IPRC_PRIO_W];
        o_src_prio[IPRC_SRC_EXT2*IPRC_PRIO_W +: IPRC_PRIO_W]   =
            reg_seven[IPRC_FLD_ML +: IPRC_PRIO_W];
        o_src_prio[IPRC_SRC_TMR5*IPRC_PRIO_W +: IPRC_PRIO_W]   =
            reg_seven[IPRC_FLD_LO +: IPRC_PRIO_W];
        o_src_prio[IPRC_SRC_CANEVT*IPRC_PRIO_W +: IPRC_PRIO_W] =
            reg_eight[IPRC_FLD_HI +: IPRC_PRIO_W];
        o_src_prio[IPRC_SRC_CANRX*IPRC_PRIO_W +: IPRC_PRIO_W]  =
            reg_eight[IPRC_FLD_MH +: IPRC_PRIO_W];
        o_src_prio[IPRC_SRC_SPIEVT*IPRC_PRIO_W +: IPRC_PRIO_W] =
            reg_eight[IPRC_FLD_ML +: IPRC_PRIO_W];
        o_src_prio[IPRC_SRC_SPIERR*IPRC_PRIO_W +: IPRC_PRIO_W] =
            reg_eight[IPRC_FLD_LO +: IPRC_PRIO_W];
        o_src_prio[IPRC_SRC_DMA3*IPRC_PRIO_W +: IPRC_PRIO_W]   =
            reg_nine[IPRC_FLD_LO +: IPRC_PRIO_W];
    end

    iprc_arbiter #(.NUM_SRC(IPRC_NUM_SRC)) u_arb (
        .i_prio   (o_src_prio),
        .i_req    (i_src_req),
        .o_winner (winner)
    );

    // Winner registered so data outputs come from flops
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq_valid <= 1'b0;
            o_irq_src   <= '0;
            o_irq_level <= '0;
        end else begin
            o_irq_valid <= winner.valid;
            o_irq_src   <= winner.src;
            o_irq_level <= winner.level;
        end
    end

endmodule : iprc_top
`default_nettype wire

// file: hdl/iprc_pkg.sv
package iprc_pkg;

    localparam int IPRC_ADDR_W   = 4;
    localparam int IPRC_DATA_W   = 32;
    localparam int IPRC_REG_W    = 16;
    localparam int IPRC_PRIO_W   = 3;
    localparam int IPRC_NUM_SRC  = 13;
    localparam int IPRC_NUM_REG  = 4;

    // Byte offsets of the priority registers
    localparam logic [IPRC_ADDR_W-1:0] IPRC_OFF_SIX   = 4'h0;
    localparam logic [IPRC_ADDR_W-1:0] IPRC_OFF_SEVEN = 4'h4;
    localparam logic [IPRC_ADDR_W-1:0] IPRC_OFF_EIGHT = 4'h8;
    localparam logic [IPRC_ADDR_W-1:0] IPRC_OFF_NINE  = 4'hC;

    // Field positions (low bit) inside a register
    localparam int IPRC_FLD_HI  = 12;
    localparam int IPRC_FLD_MH  = 8;
    localparam int IPRC_FLD_ML  = 4;
    localparam int IPRC_FLD_LO  = 0;

    // Writable bits: fully populated, and register nine
    localparam logic [IPRC_REG_W-1:0] IPRC_MASK_FULL = 16'h7777;
    localparam logic [IPRC_REG_W-1:0] IPRC_MASK_NINE = 16'h0007;
    localparam logic [IPRC_REG_W-1:0] IPRC_RST_FULL  = 16'h4444;
    localparam logic [IPRC_REG_W-1:0] IPRC_RST_NINE  = 16'h0004;

    localparam logic [IPRC_PRIO_W-1:0] IPRC_PRIO_RESET = 3'h4;
    localparam logic [IPRC_PRIO_W-1:0] IPRC_PRIO_OFF   = 3'h0;

    // Source indices in the priority vector
    typedef enum logic [3:0] {
        IPRC_SRC_DMA2,
        IPRC_SRC_OC3,
        IPRC_SRC_OC4,
        IPRC_SRC_TMR4,
        IPRC_SRC_TMR5,
        IPRC_SRC_EXT2,
        IPRC_SRC_URX,
        IPRC_SRC_UTX,
        IPRC_SRC_SPIERR,
        IPRC_SRC_SPIEVT,
        IPRC_SRC_CANRX,
        IPRC_SRC_CANEVT,
        IPRC_SRC_DMA3
    } iprc_src_e;

    typedef struct packed {
        logic                   valid;
        logic [3:0]             src;
        logic [IPRC_PRIO_W-1:0] level;
    } iprc_winner_s;

endpackage : iprc_pkg

// file: hdl/iprc_field_reg.sv
`timescale 1ns/1ps
`default_nettype none
module iprc_field_reg
    import iprc_pkg::*;
#(
    parameter logic [IPRC_REG_W-1:0] MASK      = IPRC_MASK_FULL,
    parameter logic [IPRC_REG_W-1:0] RESET_VAL = IPRC_RST_FULL
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_wr,
    input  wire logic [1:0]            i_be,
    input  wire logic [IPRC_REG_W-1:0] i_wdata,
    output logic      [IPRC_REG_W-1:0] o_value
);

    logic [IPRC_REG_W-1:0] value;
    logic [IPRC_REG_W-1:0] lane_mask;

    assign lane_mask = {{8{i_be[1]}}, {8{i_be[0]}}} & MASK;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            value <= RESET_VAL;
        end else if (i_wr) begin
            value <= (value & ~lane_mask) | (i_wdata & lane_mask);
        end
    end

    assign o_value = value & MASK;

endmodule : iprc_field_reg
`default_nettype wire

// file: hdl/iprc_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module iprc_arbiter
    import iprc_pkg::*;
#(
    parameter int NUM_SRC = IPRC_NUM_SRC
) (
    input  wire logic [NUM_SRC*IPRC_PRIO_W-1:0] i_prio,
    input  wire logic [NUM_SRC-1:0]             i_req,
    output iprc_winner_s                        o_winner
);

    logic [NUM_SRC-1:0] live;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_live
            // Code zero masks the source completely
            assign live[g] = i_req[g] &&
                (i_prio[g*IPRC_PRIO_W +: IPRC_PRIO_W] != IPRC_PRIO_OFF);
        end
    endgenerate

    // Higher code wins; ties go to the lower index
    always_comb begin
        o_winner = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (live[i] && (!o_winner.valid ||
                i_prio[i*IPRC_PRIO_W +: IPRC_PRIO_W] > o_winner.level)) begin
                o_winner.valid = 1'b1;
                o_winner.src   = 4'(i);
                o_winner.level = i_prio[i*IPRC_PRIO_W +: IPRC_PRIO_W];
            end
        end
    end

endmodule : iprc_arbiter
`default_nettype wire

// file: test/iprc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module iprc_checker
    import iprc_pkg::*;
(
    input wire logic                                i_core_clk,
    input wire logic                                i_rst,
    input wire logic [IPRC_ADDR_W-1:0]              i_address,
    input wire logic                                i_read,
    input wire logic                                i_write,
    input wire logic [IPRC_DATA_W-1:0]              i_writedata,
    input wire logic [3:0]                          i_byteenable,
    input wire logic [IPRC_DATA_W-1:0]              o_readdata,
    input wire logic                                o_waitrequest,
    input wire logic                                o_readdatavalid,
    input wire logic [IPRC_NUM_SRC-1:0]             i_src_req,
    input wire logic [IPRC_NUM_SRC*IPRC_PRIO_W-1:0] o_src_prio,
    input wire logic                                o_irq_valid,
    input wire logic [3:0]                          o_irq_src,
    input wire logic [IPRC_PRIO_W-1:0]              o_irq_level
);
    logic [IPRC_NUM_SRC-1:0]             prev_req;
    logic [IPRC_NUM_SRC*IPRC_PRIO_W-1:0] prev_prio;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            prev_req  <= '0;
            prev_prio <= '0;
        end else begin
            prev_req  <= i_src_req;
            prev_prio <= o_src_prio;
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence s_one_wait;
        o_waitrequest ##1 !o_waitrequest;
    endsequence
    property p_wait;
        $rose(i_read || i_write) |-> s_one_wait;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state count wrong");
    property p_rdv;
        o_readdatavalid |=> !o_readdatavalid;
    endproperty
    a_rdv: assert property (p_rdv) else $error("readdatavalid too long");
    property p_hi;
        o_readdata[31:16] == 16'h0;
    endproperty
    a_hi: assert property (p_hi) else $error("upper half nonzero");
    property p_gap;
        (o_readdata & 32'h0000_8888) == 32'h0;
    endproperty
    a_gap: assert property (p_gap) else $error("spacer bit set");
    property p_nine;
        i_read && !o_waitrequest && i_address == IPRC_OFF_NINE |-> o_readdata[15:3] == 13'h0;
    endproperty
    a_nine: assert property (p_nine) else $error("reg nine high bits set");
    property p_off;
        o_irq_valid |-> o_irq_level != IPRC_PRIO_OFF;
    endproperty
    a_off: assert property (p_off) else $error("disabled source won");
    property p_win;
        o_irq_valid |-> prev_req[o_irq_src] && prev_prio[o_irq_src*3 +: 3] == o_irq_level;
    endproperty
    a_win: assert property (p_win) else $error("winner level wrong");
    property p_idle;
        prev_req == '0 |-> !o_irq_valid;
    endproperty
    a_idle: assert property (p_idle) else $error("winner without request");
    property p_rst;
        $fell(i_rst) |-> o_src_prio == {IPRC_NUM_SRC{IPRC_PRIO_RESET}};
    endproperty
    a_rst: assert property (p_rst) else $error("reset priority wrong");
endmodule // iprc_checker
bind iprc_top iprc_checker u_chk (.i_core_clk, .i_rst, .i_address, .i_read, .i_write,
    .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest, .o_readdatavalid,
    .i_src_req, .o_src_prio, .o_irq_valid, .o_irq_src, .o_irq_level);
`default_nettype wire

// file: test/iprc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module iprc_src_model
    import iprc_pkg::*;
(
    input  wire logic                    i_core_clk,
    input  wire logic [IPRC_NUM_SRC-1:0] i_pattern,
    output logic      [IPRC_NUM_SRC-1:0] o_src_req
);
    // Sources raise level requests one cycle after being told
    always @(posedge i_core_clk) begin
        o_src_req <= i_pattern;
    end
endmodule // iprc_src_model
`default_nettype wire

// file: test/test_irq_priority_regs_six_to_nine.sv
`timescale 1ns/1ps
`default_nettype none
module test_irq_priority_regs_six_to_nine
    import iprc_pkg::*;
();
    logic        clk = 0, rst = 1, rd = 0, wr = 0, wreq, rdv, iv;
    logic [3:0]  addr = 0, be = 0, isrc;
    logic [31:0] wdata = 0, rdata;
    logic [12:0] pat = 0, req;
    logic [38:0] prio;
    logic [2:0]  ilvl;
    int          num_errors = 0, samples_checked = 0;
    always #10 clk = ~clk;
    iprc_src_model u_src (.i_core_clk(clk), .i_pattern(pat), .o_src_req(req));
    iprc_top u_dut (.i_core_clk(clk), .i_rst(rst), .i_address(addr), .i_read(rd),
        .i_write(wr), .i_writedata(wdata), .i_byteenable(be), .o_readdata(rdata),
        .o_waitrequest(wreq), .o_readdatavalid(rdv), .i_src_req(req), .o_src_prio(prio),
        .o_irq_valid(iv), .o_irq_src(isrc), .o_irq_level(ilvl));
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d,
                       input logic [3:0] b, output logic [31:0] q);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        addr  <= a;
        wdata <= {16'h0, d};
        be    <= b;
        rd    <= !w;
        wr    <= w;
        // Waitrequest judged settled mid-cycle; the following rise accepts
        do begin
            @(negedge clk);
            n++;
            done = !wreq;
            if (done) chk("readdatavalid", {63'h0, !w}, {63'h0, rdv});
            @(posedge clk);
        end while (!done && n < 50);
        q = rdata;
        chk("accept", 64'h1, {63'h0, done});
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wr16(input logic [3:0] a, input logic [15:0] d, input logic [3:0] b);
        logic [31:0] q;
        bus(1'b1, a, d, b, q);
    endtask
    task automatic rdc(input string what, input logic [3:0] a, input logic [15:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 16'h0, 4'hF, q);
        chk(what, {16'h0, exp}, q);
    endtask
    task automatic arb(input logic [12:0] p, input logic v, input logic [3:0] s,
                       input logic [2:0] l);
        @(posedge clk);
        pat <= p;
        repeat (2) @(posedge clk);
        #1;
        chk("irq", {24'h0, v, s, l}, {24'h0, iv, iv ? {isrc, ilvl} : 7'h0});
    endtask
    task automatic t_reset;
        rdc("six", IPRC_OFF_SIX, 16'h4444);
        rdc("seven", IPRC_OFF_SEVEN, 16'h4444);
        rdc("eight", IPRC_OFF_EIGHT, 16'h4444);
        rdc("nine", IPRC_OFF_NINE, 16'h0004);
    endtask
    task automatic t_mask;
        for (int i = 0; i < 4; i++) begin
            wr16(4'(i * 4), 16'hFFFF, 4'h3);
            rdc("ones", 4'(i * 4), i == 3 ? 16'h0007 : 16'h7777);
        end
        wr16(IPRC_OFF_SIX, 16'h0000, 4'h1);
        rdc("lane", IPRC_OFF_SIX, 16'h7700);
        wr16(4'h2, 16'hFFFF, 4'h3);
        rdc("unmapped", 4'h2, 16'h0000);
    endtask
    task automatic t_map;
        logic [2:0] code [13] = '{4, 3, 2, 1, 1, 7, 6, 5, 5, 4, 3, 2, 6};
        wr16(IPRC_OFF_SIX, 16'h1234, 4'h3);
        wr16(IPRC_OFF_SEVEN, 16'h5671, 4'h3);
        wr16(IPRC_OFF_EIGHT, 16'h2345, 4'h3);
        wr16(IPRC_OFF_NINE, 16'hFFFE, 4'h3);
        for (int i = 0; i < 13; i++) begin
            chk("field", {61'h0, code[i]}, {61'h0, prio[i*3 +: 3]});
            arb(13'h1 << i, 1'b1, 4'(i), code[i]);
        end
        arb(13'h1FFF, 1'b1, IPRC_SRC_EXT2, 3'h7);
        arb(13'h0018, 1'b1, IPRC_SRC_TMR4, 3'h1);
        wr16(IPRC_OFF_SIX, 16'h1230, 4'h1);
        arb(13'h0001, 1'b0, 4'h0, 3'h0);
        arb(13'h0009, 1'b1, IPRC_SRC_TMR4, 3'h1);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("rst prio", {25'h0, {13{IPRC_PRIO_RESET}}}, {25'h0, prio});
        t_reset();
        t_mask();
        t_map();
        tally_and_finish();
    end
endmodule // test_irq_priority_regs_six_to_nine
`default_nettype wire
